// file: hdl/rpsel_cfg.svh
// Purpose: constants for the remappable output select block
// Assumes: apb byte addresses, 32-bit data, 16-bit registers in the low half
// Notes:   field positions and masks shared by the top and the register store
`ifndef RPSEL_CFG_SVH
`define RPSEL_CFG_SVH

`define RPSEL_OFF_SEL4     12'h000
`define RPSEL_OFF_SEL5     12'h004
`define RPSEL_OFF_STATUS   12'h008
`define RPSEL_HI_LSB       8
`define RPSEL_LO_LSB       0
`define RPSEL_FIELD_W      6
`define RPSEL_REG_MASK     16'h3f3f
`define RPSEL_SEL_RESET    16'h0000
`define RPSEL_NUM_FUNCS    6'h10

`endif

// file: hdl/rpsel_pkg.sv
// Purpose: types for the remappable output select block
// Assumes: four remappable pins, six-bit function codes
// Notes:   constants live in rpsel_cfg.svh
package rpsel_pkg;

  typedef logic [5:0] rpsel_code_type;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } rpsel_apb_req_type;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } rpsel_apb_rsp_type;

  typedef struct packed {
    logic pin55;
    logic pin54;
    logic pin43;
    logic pin42;
  } rpsel_pins_type;

endpackage

// file: hdl/rpsel_store.sv
// Purpose: holds the two output select registers
// Assumes: one write strobe with a register select, data masked here on write
// Notes:   read data come out of a register, one cycle after the address
`timescale 1ns/1ps
`include "rpsel_cfg.svh"

module rpsel_store (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        wr_en,
  input  wire logic        wr_sel,
  input  wire logic [15:0] wr_data,
  input  wire logic        rd_sel,
  output logic      [15:0] rd_data,
  output logic      [15:0] sel4,
  output logic      [15:0] sel5
);
  logic [15:0] next_sel4;
  logic [15:0] next_sel5;
  logic [15:0] next_rd_data;

  always_comb begin
    next_sel4    = sel4;
    next_sel5    = sel5;
    if (wr_en && !wr_sel) begin
      next_sel4 = wr_data & `RPSEL_REG_MASK;
    end
    if (wr_en && wr_sel) begin
      next_sel5 = wr_data & `RPSEL_REG_MASK;
    end
    next_rd_data = rd_sel ? sel5 : sel4;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sel4    <= `RPSEL_SEL_RESET;
      sel5    <= `RPSEL_SEL_RESET;
      rd_data <= 16'h0000;
    end else begin
      sel4    <= next_sel4;
      sel5    <= next_sel5;
      rd_data <= next_rd_data;
    end
  end
endmodule

// file: hdl/rpsel_top.sv
// Purpose: output-side pin selection for four remappable pins, apb slave
// Assumes: synchronous active-low reset, 10 MHz system clock
// Notes:   pin outputs are registered, so routing lags the peripheral by one cycle
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "rpsel_cfg.svh"

// What this block does
// - register four bits 13..8 choose the function driving pin 43.
// - register four bits 5..0 choose the function driving pin 42.
// - register five bits 13..8 choose the function driving pin 55.
// - register five bits 5..0 choose the function driving pin 54.
// - bits 15..14 and 7..6 read zero and ignore writes.
module rpsel_top (
  input  wire logic                     SYS_CLK,
  input  wire logic                     RESET_N,
  input  wire rpsel_pkg::rpsel_apb_req_type APB_REQ,
  output rpsel_pkg::rpsel_apb_rsp_type  APB_RSP,
  input  wire logic [15:0]              PERIPH_OUT,
  input  wire rpsel_pkg::rpsel_pins_type PORT_OUT,
  output rpsel_pkg::rpsel_pins_type     PIN_OUT,
  output rpsel_pkg::rpsel_pins_type     PIN_REMAPPED
);
  import rpsel_pkg::*;

  // two-phase read: the store registers its read data, so reads take one extra cycle
  typedef enum {ST_IDLE, ST_WAIT, ST_DONE} rpsel_state_type;

  rpsel_state_type   state;
  rpsel_state_type   next_state;
  rpsel_apb_rsp_type next_rsp;
  rpsel_pins_type    next_pin_out;
  rpsel_pins_type    next_remapped;
  logic              wr_en;
  logic              wr_sel;
  logic              rd_sel;
  logic              hit_sel;
  logic              hit_status;
  logic [15:0]       rd_data;
  logic [15:0]       sel4;
  logic [15:0]       sel5;

  // function code to peripheral output; code zero and codes beyond the table route the port level
  function automatic logic code_valid(input rpsel_code_type code);
    code_valid = (code != 6'h00) && (code < `RPSEL_NUM_FUNCS);
  endfunction

  function automatic logic route_pin(input rpsel_code_type code, input logic [15:0] periph,
                                     input logic port_level);
    route_pin = code_valid(code) ? periph[code[3:0]] : port_level;
  endfunction

  function automatic rpsel_code_type field_of(input logic [15:0] r, input logic hi);
    field_of = hi ? r[`RPSEL_HI_LSB +: `RPSEL_FIELD_W] : r[`RPSEL_LO_LSB +: `RPSEL_FIELD_W];
  endfunction

  assign hit_sel    = (APB_REQ.paddr == `RPSEL_OFF_SEL4) || (APB_REQ.paddr == `RPSEL_OFF_SEL5);
  assign hit_status = (APB_REQ.paddr == `RPSEL_OFF_STATUS);
  assign rd_sel     = (APB_REQ.paddr == `RPSEL_OFF_SEL5);
  assign wr_sel     = rd_sel;
  // writes land only at the edge where the master sees pready high, i.e. while in done
  assign wr_en      = APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite && hit_sel
                      && (state == ST_DONE);

  rpsel_store u_store (
    .clk     (SYS_CLK),
    .rst_n   (RESET_N),
    .wr_en   (wr_en),
    .wr_sel  (wr_sel),
    .wr_data (APB_REQ.pwdata[15:0]),
    .rd_sel  (rd_sel),
    .rd_data (rd_data),
    .sel4    (sel4),
    .sel5    (sel5)
  );

  always_comb begin
    next_state      = state;
    next_rsp        = APB_RSP;
    next_rsp.pready = 1'b0;
    case (state)
      ST_IDLE: begin
        if (APB_REQ.psel && !APB_REQ.penable) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        next_state       = ST_DONE;
        next_rsp.pready  = 1'b1;
        next_rsp.pslverr = !(hit_sel || hit_status);
        next_rsp.prdata  = 32'h0000_0000;
        if (!APB_REQ.pwrite && hit_sel) begin
          next_rsp.prdata = {16'h0000, rd_data & `RPSEL_REG_MASK};
        end else if (!APB_REQ.pwrite && hit_status) begin
          next_rsp.prdata = {28'h0000000, PIN_REMAPPED};
        end
      end
      ST_DONE: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // next pin levels and remapped flags, decoded from the stored select fields
  always_comb begin
    next_remapped.pin43 = code_valid(field_of(sel4, 1'b1));
    next_remapped.pin42 = code_valid(field_of(sel4, 1'b0));
    next_remapped.pin55 = code_valid(field_of(sel5, 1'b1));
    next_remapped.pin54 = code_valid(field_of(sel5, 1'b0));
    next_pin_out.pin43  = route_pin(field_of(sel4, 1'b1), PERIPH_OUT, PORT_OUT.pin43);
    next_pin_out.pin42  = route_pin(field_of(sel4, 1'b0), PERIPH_OUT, PORT_OUT.pin42);
    next_pin_out.pin55  = route_pin(field_of(sel5, 1'b1), PERIPH_OUT, PORT_OUT.pin55);
    next_pin_out.pin54  = route_pin(field_of(sel5, 1'b0), PERIPH_OUT, PORT_OUT.pin54);
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      state        <= ST_IDLE;
      APB_RSP      <= '0;
      PIN_OUT      <= '0;
      PIN_REMAPPED <= '0;
    end else begin
      state        <= next_state;
      APB_RSP      <= next_rsp;
      PIN_OUT      <= next_pin_out;
      PIN_REMAPPED <= next_remapped;
    end
  end

  a_unimpl_zero: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    APB_RSP.pready |-> (APB_RSP.prdata[15:14] == 2'b00) && (APB_RSP.prdata[7:6] == 2'b00))
    else $error("unimplemented bits read nonzero");

  a_store_masked: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    ((sel4 & ~`RPSEL_REG_MASK) == 16'h0000) && ((sel5 & ~`RPSEL_REG_MASK) == 16'h0000))
    else $error("unimplemented bits stored");

  a_pin43_route: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    ##1 PIN_OUT.pin43 == route_pin($past(sel4[13:8]), $past(PERIPH_OUT), $past(PORT_OUT.pin43)))
    else $error("pin 43 misrouted");

  a_pin42_route: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    ##1 PIN_OUT.pin42 == route_pin($past(sel4[5:0]), $past(PERIPH_OUT), $past(PORT_OUT.pin42)))
    else $error("pin 42 misrouted");

  a_pin55_route: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    ##1 PIN_OUT.pin55 == route_pin($past(sel5[13:8]), $past(PERIPH_OUT), $past(PORT_OUT.pin55)))
    else $error("pin 55 misrouted");

  a_pin54_route: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    ##1 PIN_OUT.pin54 == route_pin($past(sel5[5:0]), $past(PERIPH_OUT), $past(PORT_OUT.pin54)))
    else $error("pin 54 misrouted");

  a_zero_code_port: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    (sel4[5:0] == 6'h00) |=> (PIN_OUT.pin42 == $past(PORT_OUT.pin42)) && !PIN_REMAPPED.pin42)
    else $error("zero code did not release pin 42");

  a_write_lands: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    (wr_en && !wr_sel) |=> sel4 == ($past(APB_REQ.pwdata[15:0]) & `RPSEL_REG_MASK))
    else $error("register four write lost");

  a_ready_pulse: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    APB_RSP.pready |=> !APB_RSP.pready)
    else $error("pready held more than one cycle");
endmodule

// file: testbench/rpsel_pads_model.sv
// Purpose: pad-side view of the four remappable pins
// Assumes: pads follow the block's pin levels directly
// Notes:   no pull on the pads, the block drives them at all times
`timescale 1ns/1ps

module rpsel_pads_model (
  input  wire rpsel_pkg::rpsel_pins_type pin_out,
  output rpsel_pkg::rpsel_pins_type      pad_level
);
  import rpsel_pkg::*;
  assign pad_level = pin_out;
endmodule

// file: testbench/tb_top.sv
// Purpose: self-checking bench for the remappable output select block
// Assumes: apb answers within a few cycles, pins follow one edge after a write
// Notes:   pins are checked at the pads, registers over apb
`timescale 1ns/1ps
`include "rpsel_cfg.svh"

module tb_top;
  import rpsel_pkg::*;
  logic              SYS_CLK;
  logic              RESET_N;
  rpsel_apb_req_type APB_REQ;
  rpsel_apb_rsp_type APB_RSP;
  logic [15:0]       PERIPH_OUT;
  rpsel_pins_type    PORT_OUT;
  rpsel_pins_type    PIN_OUT;
  rpsel_pins_type    PIN_REMAPPED;
  rpsel_pins_type    pad;
  logic [31:0]       rd;
  logic              perr;
  logic [15:0]       pat [2] = '{16'h5a3c, 16'ha5c3};
  logic [5:0]        bad [3] = '{6'h00, 6'h10, 6'h3f};
  int                n_fail = 0;
  int                n_tests = 0;

  rpsel_top u_rpsel_top (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .APB_REQ(APB_REQ), .APB_RSP(APB_RSP),
    .PERIPH_OUT(PERIPH_OUT), .PORT_OUT(PORT_OUT), .PIN_OUT(PIN_OUT), .PIN_REMAPPED(PIN_REMAPPED));
  rpsel_pads_model u_rpsel_pads_model (.pin_out(PIN_OUT), .pad_level(pad));

  initial begin
    SYS_CLK = 1'b0;
    forever #50 SYS_CLK = ~SYS_CLK;
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge SYS_CLK);
    APB_REQ <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge SYS_CLK);
    APB_REQ.penable <= 1'b1;
    // look mid-cycle so the value seen is the one standing at the next rising edge
    do begin
      @(negedge SYS_CLK);
      t++;
    end while (APB_RSP.pready !== 1'b1 && t < 20);
    rd = APB_RSP.prdata;
    perr = APB_RSP.pslverr;
    @(posedge SYS_CLK);
    APB_REQ <= '0;
    if (t >= 20) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
    end
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  initial begin
    APB_REQ = '0;
    PERIPH_OUT = 16'h0;
    PORT_OUT = '0;
    RESET_N = 1'b0;
    repeat (3) @(posedge SYS_CLK);
    RESET_N <= 1'b1;
    rchk(`RPSEL_OFF_SEL4, 32'h0);
    rchk(`RPSEL_OFF_SEL5, 32'h0);
    apb(1'b1, `RPSEL_OFF_SEL4, 32'hffff_ffff);
    rchk(`RPSEL_OFF_SEL4, 32'h3f3f);
    apb(1'b1, `RPSEL_OFF_SEL5, 32'hffff_c0c0);
    rchk(`RPSEL_OFF_SEL5, 32'h0);
    $display("test reset_and_reserved done");
    // the two fields of each register get different codes, except at k = 8, so a swapped field shows up
    for (int k = 1; k < 16; k++) begin
      apb(1'b1, `RPSEL_OFF_SEL4, {18'h0, 6'(k), 2'b00, 6'(16 - k)});
      apb(1'b1, `RPSEL_OFF_SEL5, {18'h0, 6'(16 - k), 2'b00, 6'(k)});
      for (int p = 0; p < 2; p++) begin
        PERIPH_OUT <= pat[p];
        PORT_OUT <= 4'(p * 15);
        repeat (3) @(posedge SYS_CLK);
        chk({28'h0, pad[3:2]}, {30'h0, pat[p][16 - k], pat[p][k]});
        chk({28'h0, pad[1:0]}, {30'h0, pat[p][k], pat[p][16 - k]});
        rchk(`RPSEL_OFF_STATUS, 32'hf);
      end
    end
    $display("test routing done");
    for (int c = 0; c < 3; c++) begin
      apb(1'b1, `RPSEL_OFF_SEL4, {18'h0, bad[c], 2'b11, bad[c]});
      apb(1'b1, `RPSEL_OFF_SEL5, {18'h0, bad[c], 2'b11, bad[c]});
      rchk(`RPSEL_OFF_SEL5, {18'h0, bad[c], 2'b00, bad[c]});
      for (int v = 5; v < 11; v += 5) begin
        PERIPH_OUT <= 16'hffff;
        PORT_OUT <= 4'(v);
        repeat (3) @(posedge SYS_CLK);
        chk({28'h0, pad}, 32'(v));
        chk({28'h0, PIN_REMAPPED}, 32'h0);
      end
    end
    $display("test unrouted_codes done");
    apb(1'b1, 12'h00c, 32'h0000_0101);
    chk({31'h0, perr}, 32'h1);
    rchk(`RPSEL_OFF_SEL4, 32'h3f3f);
    $display("test unmapped_address done");
    tally_and_finish;
  end

  initial begin
    repeat (20000) @(posedge SYS_CLK);
    n_fail++;
    tally_and_finish;
  end
endmodule
